// File: ctl_consts.vh
// constants for the cell trace and link counter block
`ifndef CTL_CONSTS_VH
`define CTL_CONSTS_VH

// trace word field positions
`define CTL_CONN_LO 0
`define CTL_CONN_HI 15
`define CTL_REASON_LO 16
`define CTL_REASON_HI 20
`define CTL_MAINT_BIT 21
`define CTL_SEC_BIT 22
`define CTL_PRI_BIT 23
`define CTL_TYPE_LO 24
`define CTL_TYPE_HI 27
`define CTL_REM_BIT 28
`define CTL_SRC_LO 29
`define CTL_SRC_HI 31

// counter record word indices
`define CTL_IN_USER0 3'h0
`define CTL_IN_USER1 3'h1
`define CTL_IN_OAM0 3'h2
`define CTL_IN_OAM1 3'h3
`define CTL_IN_UNMATCHED_CELL_COUNT 3'h4
`define CTL_OUT_USER0 3'h0
`define CTL_OUT_USER1 3'h1
`define CTL_OUT_OAM0 3'h2
`define CTL_OUT_OAM1 3'h3

// register port offsets
`define CTL_REG_CONFIG 4'h0
`define CTL_REG_WR_PTR 4'h1
`define CTL_REG_BASE 4'h2
`define CTL_REG_IN_BASE 4'h3
`define CTL_REG_OUT_BASE 4'h4

// reset values and step constants
`define CTL_CONFIG_RST 3'h0
`define CTL_BASE_RST 24'h000000
`define CTL_ONE_WORD 24'h000001
`define CTL_REC_STEP 24'h000002
`define CTL_ZERO32 32'h00000000
`define CTL_ONE32 32'h00000001

`endif

// File: ctl_counter_rmw.v
// read-modify-write engine for the wrapping 32-bit link counters
`timescale 1ns/1ns
`default_nettype none
`include "ctl_consts.vh"

module ctl_counter_rmw #(
    parameter AW = 24
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // request
    input wire req_valid,
    input wire [AW-1:0] req_addr,
    output reg req_ready,
    // memory read port
    output reg rd_req,
    output reg [AW-1:0] rd_addr,
    input wire rd_valid,
    input wire [31:0] rd_data,
    // memory write port
    output reg wr_req,
    output reg [AW-1:0] wr_addr,
    output reg [31:0] wr_data,
    input wire wr_ack
);

// ----------------------------------------
// state machine
// ----------------------------------------
localparam S_IDLE = 2'b00;
localparam S_READ = 2'b01;
localparam S_WRITE = 2'b10;

reg [1:0] state_q;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_q <= S_IDLE;
        req_ready <= 1'b1;
        rd_req <= 1'b0;
        rd_addr <= `CTL_BASE_RST;
        wr_req <= 1'b0;
        wr_addr <= `CTL_BASE_RST;
        wr_data <= `CTL_ZERO32;
    end else begin
        case (state_q)
            S_IDLE: begin
                if (req_valid) begin
                    rd_req <= 1'b1;
                    rd_addr <= req_addr;
                    wr_addr <= req_addr;
                    req_ready <= 1'b0;
                    state_q <= S_READ;
                end
            end
            S_READ: begin
                if (rd_valid) begin
                    rd_req <= 1'b0;
                    // plain add wraps past all ones
                    wr_data <= rd_data + `CTL_ONE32;
                    wr_req <= 1'b1;
                    state_q <= S_WRITE;
                end
            end
            S_WRITE: begin
                if (wr_ack) begin
                    wr_req <= 1'b0;
                    req_ready <= 1'b1;
                    state_q <= S_IDLE;
                end
            end
            default: begin
                state_q <= S_IDLE;
            end
        endcase
    end
end

endmodule // ctl_counter_rmw
`default_nettype wire

// File: ctl_trace_top.v
// cell trace table writer and link statistics updater
`timescale 1ns/1ns
`default_nettype none
`include "ctl_consts.vh"

// Operation
// - one two-word trace record per cell time
// - table size from config, wraps to start
// - egress connection id in low half-word
// - egress word holds source and cell type
// - egress removed flag mirrors cell removal
// - egress primary copy flag, previous cell read
// - egress secondary copy flag, unfiltered and read
// - maintenance flag when previous slot was maintenance
// - egress reason code records processing outcome
// - ingress word holds source, type, reason, id
// - ingress removed flag mirrors cell removal
// - ingress copy flags for previous extracted cells
// - nonconforming flag from usage parameter control
// - counters are 32 bit and wrap
// - ingress record has five counters in order
// - non-oam ingress cell bumps user counter by clp
// - oam ingress cell bumps oam counter by clp
// - no valid ingress id bumps inactive counter
// - egress record has four counters in order
// - oam egress cell bumps oam counter by clp
module ctl_trace_top #(
    parameter AW = 24,
    parameter SIZE_W = 3,
    parameter MIN_RECS = 64
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // cell time strobe and maintenance indication
    input wire cell_tick,
    input wire prev_maint_slot,
    // egress trace inputs
    input wire [2:0] egress_trace_source,
    input wire egress_trace_removed,
    input wire [3:0] egress_trace_cell_type,
    input wire egress_trace_primary_copy,
    input wire egress_trace_secondary_copy,
    input wire [4:0] egress_trace_reason,
    input wire [15:0] egress_conn_id,
    input wire egress_oam,
    input wire egress_clp,
    input wire egress_sent,
    // ingress trace inputs
    input wire [2:0] ingress_trace_source,
    input wire ingress_trace_removed,
    input wire [3:0] ingress_trace_cell_type,
    input wire ingress_trace_primary_copy,
    input wire ingress_trace_secondary_copy,
    input wire trace_nonconforming,
    input wire [4:0] ingress_trace_reason,
    input wire [15:0] ingress_conn_id,
    input wire ingress_oam,
    input wire ingress_clp,
    input wire ingress_arrived,
    input wire ingress_id_valid,
    // memory read port
    output reg mem_rd_req,
    output reg [AW-1:0] mem_rd_addr,
    input wire mem_rd_valid,
    input wire [31:0] mem_rd_data,
    // memory write port
    output reg mem_wr_req,
    output reg [AW-1:0] mem_wr_addr,
    output reg [31:0] mem_wr_data,
    input wire mem_wr_ack,
    // status
    output reg busy
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [SIZE_W-1:0] trace_table_size_q;
reg [AW-1:0] base_q;
reg [AW-1:0] in_base_q;
reg [AW-1:0] out_base_q;
reg [AW-1:0] wr_ptr_q;
reg [AW-1:0] table_end;
reg [31:0] table_span;

always @* begin
    // record count doubles per size step, two words each
    table_span = (MIN_RECS * 2) << trace_table_size_q;
    // spans wider than the address bus are not supported
    table_end = base_q + table_span[AW-1:0] - `CTL_REC_STEP;
end

// ----------------------------------------
// pointer wrap
// ----------------------------------------
// compare against the last record, not one past it
wire ptr_at_end = (wr_ptr_q >= table_end);

// ----------------------------------------
// captured words and events
// ----------------------------------------
reg [31:0] egress_word_q;
reg [31:0] ingress_word_q;
reg pend_rec_q;
reg [2:0] ev_pend_q;
reg [AW-1:0] ev_addr_q [0:2];
reg [31:0] egress_word_d;
reg [31:0] ingress_word_d;
reg [2:0] in_sel;
reg [2:0] out_sel;

always @* begin
    egress_word_d = `CTL_ZERO32;
    egress_word_d[`CTL_CONN_HI:`CTL_CONN_LO] = egress_conn_id;
    egress_word_d[`CTL_SRC_HI:`CTL_SRC_LO] = egress_trace_source;
    egress_word_d[`CTL_TYPE_HI:`CTL_TYPE_LO] = egress_trace_cell_type;
    egress_word_d[`CTL_REM_BIT] = egress_trace_removed;
    egress_word_d[`CTL_PRI_BIT] = egress_trace_primary_copy;
    egress_word_d[`CTL_SEC_BIT] = egress_trace_secondary_copy;
    egress_word_d[`CTL_MAINT_BIT] = prev_maint_slot;
    egress_word_d[`CTL_REASON_HI:`CTL_REASON_LO] = egress_trace_reason;
    ingress_word_d = `CTL_ZERO32;
    ingress_word_d[`CTL_CONN_HI:`CTL_CONN_LO] = ingress_conn_id;
    ingress_word_d[`CTL_SRC_HI:`CTL_SRC_LO] = ingress_trace_source;
    ingress_word_d[`CTL_TYPE_HI:`CTL_TYPE_LO] = ingress_trace_cell_type;
    ingress_word_d[`CTL_REASON_HI:`CTL_REASON_LO] = ingress_trace_reason;
    ingress_word_d[`CTL_REM_BIT] = ingress_trace_removed;
    ingress_word_d[`CTL_PRI_BIT] = ingress_trace_primary_copy;
    ingress_word_d[`CTL_SEC_BIT] = ingress_trace_secondary_copy;
    ingress_word_d[`CTL_MAINT_BIT] = trace_nonconforming;
    // ingress record word order fixed by index
    if (!ingress_id_valid) begin
        in_sel = `CTL_IN_UNMATCHED_CELL_COUNT;
    end else if (ingress_oam) begin
        in_sel = ingress_clp ? `CTL_IN_OAM1 : `CTL_IN_OAM0;
    end else begin
        in_sel = ingress_clp ? `CTL_IN_USER1 : `CTL_IN_USER0;
    end
    if (egress_oam) begin
        out_sel = egress_clp ? `CTL_OUT_OAM1 : `CTL_OUT_OAM0;
    end else begin
        out_sel = egress_clp ? `CTL_OUT_USER1 : `CTL_OUT_USER0;
    end
end

// ----------------------------------------
// counter engine
// ----------------------------------------
reg cnt_valid;
reg [AW-1:0] cnt_addr;
wire cnt_ready;
wire cnt_rd_req;
wire [AW-1:0] cnt_rd_addr;
wire cnt_wr_req;
wire [AW-1:0] cnt_wr_addr;
wire [31:0] cnt_wr_data;
reg eng_wr_ack;

ctl_counter_rmw #(
    .AW(AW)
) u_rmw (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .req_valid(cnt_valid),
    .req_addr(cnt_addr),
    .req_ready(cnt_ready),
    .rd_req(cnt_rd_req),
    .rd_addr(cnt_rd_addr),
    .rd_valid(mem_rd_valid),
    .rd_data(mem_rd_data),
    .wr_req(cnt_wr_req),
    .wr_addr(cnt_wr_addr),
    .wr_data(cnt_wr_data),
    .wr_ack(eng_wr_ack)
);

// ----------------------------------------
// trace writer state machine
// ----------------------------------------
localparam T_IDLE = 2'b00;
localparam T_EGR = 2'b01;
localparam T_ING = 2'b10;

reg [1:0] tstate_q;
reg trace_wr;
reg [AW-1:0] trace_addr;
reg [31:0] trace_data;

// trace words take the write port first; counters wait
always @* begin
    cnt_valid = 1'b0;
    cnt_addr = ev_addr_q[0];
    if (tstate_q == T_IDLE && !pend_rec_q) begin
        if (ev_pend_q[0]) begin
            cnt_valid = 1'b1;
            cnt_addr = ev_addr_q[0];
        end else if (ev_pend_q[1]) begin
            cnt_valid = 1'b1;
            cnt_addr = ev_addr_q[1];
        end else if (ev_pend_q[2]) begin
            cnt_valid = 1'b1;
            cnt_addr = ev_addr_q[2];
        end
    end
    trace_wr = (tstate_q != T_IDLE);
    trace_addr = (tstate_q == T_ING) ? wr_ptr_q + `CTL_ONE_WORD : wr_ptr_q;
    trace_data = (tstate_q == T_ING) ? ingress_word_q : egress_word_q;
    eng_wr_ack = mem_wr_ack && !trace_wr;
end

// grant follows the same priority as the request mux
wire accept = cnt_valid && cnt_ready;
wire [2:0] grant = !accept ? 3'b000 : ev_pend_q[0] ? 3'b001 : ev_pend_q[1] ? 3'b010 : 3'b100;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        tstate_q <= T_IDLE;
        wr_ptr_q <= `CTL_BASE_RST;
        pend_rec_q <= 1'b0;
        ev_pend_q <= 3'b000;
        ev_addr_q[0] <= `CTL_BASE_RST;
        ev_addr_q[1] <= `CTL_BASE_RST;
        ev_addr_q[2] <= `CTL_BASE_RST;
        egress_word_q <= `CTL_ZERO32;
        ingress_word_q <= `CTL_ZERO32;
    end else begin
        // a new cell time overrides an unfinished one; set beats clear
        if (cell_tick) begin
            egress_word_q <= egress_word_d;
            ingress_word_q <= ingress_word_d;
            pend_rec_q <= 1'b1;
            ev_pend_q[0] <= ingress_arrived || (ev_pend_q[0] && !grant[0]);
            // slot one is spare, kept for a third event source
            ev_pend_q[1] <= 1'b0;
            ev_pend_q[2] <= egress_sent || (ev_pend_q[2] && !grant[2]);
            ev_addr_q[0] <= in_base_q + {{(AW-3){1'b0}}, in_sel};
            ev_addr_q[2] <= out_base_q + {{(AW-3){1'b0}}, out_sel};
        end else begin
            ev_pend_q <= ev_pend_q & ~grant;
        end
        case (tstate_q)
            T_IDLE: begin
                if (pend_rec_q && !cell_tick && cnt_ready) begin
                    pend_rec_q <= 1'b0;
                    tstate_q <= T_EGR;
                end
            end
            T_EGR: begin
                if (mem_wr_ack) begin
                    tstate_q <= T_ING;
                end
            end
            T_ING: begin
                if (mem_wr_ack) begin
                    tstate_q <= T_IDLE;
                    if (ptr_at_end) begin
                        wr_ptr_q <= base_q;
                    end else begin
                        wr_ptr_q <= wr_ptr_q + `CTL_REC_STEP;
                    end
                end
            end
            default: begin
                tstate_q <= T_IDLE;
            end
        endcase
    end
end

// ----------------------------------------
// busy status
// ----------------------------------------
// queued counter events count as work, else busy
// dips low between the trace and the counters
wire work_left = trace_wr || !cnt_ready || pend_rec_q || (ev_pend_q != 3'h0);

// ----------------------------------------
// memory port outputs
// ----------------------------------------
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        mem_rd_req <= 1'b0;
        mem_rd_addr <= `CTL_BASE_RST;
        mem_wr_req <= 1'b0;
        mem_wr_addr <= `CTL_BASE_RST;
        mem_wr_data <= `CTL_ZERO32;
        busy <= 1'b0;
    end else begin
        // drop the read once answered; the engine lowers its own on the same edge
        mem_rd_req <= cnt_rd_req && !mem_rd_valid;
        mem_rd_addr <= cnt_rd_addr;
        // drop the request on the ack so no double write
        mem_wr_req <= (trace_wr || cnt_wr_req) && !mem_wr_ack;
        mem_wr_addr <= trace_wr ? trace_addr : cnt_wr_addr;
        mem_wr_data <= trace_wr ? trace_data : cnt_wr_data;
        busy <= work_left;
    end
end

// ----------------------------------------
// register port
// ----------------------------------------
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        trace_table_size_q <= `CTL_CONFIG_RST;
        base_q <= `CTL_BASE_RST;
        in_base_q <= `CTL_BASE_RST;
        out_base_q <= `CTL_BASE_RST;
        reg_rdata <= `CTL_ZERO32;
    end else begin
        if (reg_wr) begin
            case (reg_addr)
                `CTL_REG_CONFIG: trace_table_size_q <= reg_wdata[SIZE_W-1:0];
                `CTL_REG_BASE: base_q <= reg_wdata[AW-1:0];
                `CTL_REG_IN_BASE: in_base_q <= reg_wdata[AW-1:0];
                `CTL_REG_OUT_BASE: out_base_q <= reg_wdata[AW-1:0];
                default: begin
                end
            endcase
        end
        reg_rdata <= `CTL_ZERO32;
        if (reg_rd) begin
            case (reg_addr)
                `CTL_REG_CONFIG: reg_rdata <= {{(32-SIZE_W){1'b0}}, trace_table_size_q};
                `CTL_REG_WR_PTR: reg_rdata <= {{(32-AW){1'b0}}, wr_ptr_q};
                `CTL_REG_BASE: reg_rdata <= {{(32-AW){1'b0}}, base_q};
                `CTL_REG_IN_BASE: reg_rdata <= {{(32-AW){1'b0}}, in_base_q};
                `CTL_REG_OUT_BASE: reg_rdata <= {{(32-AW){1'b0}}, out_base_q};
                default: reg_rdata <= `CTL_ZERO32;
            endcase
        end
    end
end

endmodule // ctl_trace_top
`default_nettype wire

// File: ctl_trace_top_assertions.sv
// assertion checker for the trace and counter block
`timescale 1ns/1ns
`default_nettype none
module ctl_trace_checker #(
    parameter AW = 24
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // cell time and status
    input wire logic cell_tick,
    input wire logic busy,
    // memory ports
    input wire logic mem_rd_req,
    input wire logic [AW-1:0] mem_rd_addr,
    input wire logic mem_rd_valid,
    input wire logic [31:0] mem_rd_data,
    input wire logic mem_wr_req,
    input wire logic [AW-1:0] mem_wr_addr,
    input wire logic [31:0] mem_wr_data,
    input wire logic mem_wr_ack
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // last counter read, for the increment check
    // ----------------------------------------
    logic [AW-1:0] rd_addr_q;
    logic [31:0] rd_data_q;
    logic rd_seen_q;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_seen_q <= 1'b0;
            rd_addr_q <= '0;
            rd_data_q <= 32'h0;
        end else if (mem_rd_req && mem_rd_valid) begin
            rd_seen_q <= 1'b1;
            rd_addr_q <= mem_rd_addr;
            rd_data_q <= mem_rd_data;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    wr_held_a: assert property (mem_wr_req && !mem_wr_ack |=> mem_wr_req && $stable(mem_wr_addr) && $stable(mem_wr_data))
        else $error("write request dropped or changed before ack");
    rd_held_a: assert property (mem_rd_req && !mem_rd_valid |=> mem_rd_req && $stable(mem_rd_addr))
        else $error("read request dropped or changed before data");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    unmapped_zero_a: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 32'h0)
        else $error("unmapped register read not zero");
    count_wrap_a: assert property (rd_seen_q && mem_wr_req && mem_wr_addr == rd_addr_q |-> mem_wr_data == rd_data_q + 32'h1)
        else $error("counter write is not read value plus one");
    rmw_write_a: assert property (mem_rd_req && mem_rd_valid |-> ##[1:4] (mem_wr_req && mem_wr_addr == rd_addr_q))
        else $error("counter read not followed by its write");
    tick_busy_a: assert property (cell_tick && !busy |-> ##[1:4] busy)
        else $error("busy not raised after cell time");
    tick_write_a: assert property (cell_tick && !busy |-> ##[2:6] mem_wr_req)
        else $error("no trace write after cell time");
endmodule // ctl_trace_checker
bind ctl_trace_top ctl_trace_checker #(.AW(AW)) u_chk (.core_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata,
    .cell_tick, .busy, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .mem_wr_req, .mem_wr_addr,
    .mem_wr_data, .mem_wr_ack);
`default_nettype wire

// File: ctl_mem_model.sv
// external memory model holding trace and counter tables
`timescale 1ns/1ns
`default_nettype none
module ctl_mem_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // answer latency in cycles
    input wire logic [1:0] lat,
    // read port
    input wire logic mem_rd_req,
    input wire logic [23:0] mem_rd_addr,
    output logic mem_rd_valid,
    output logic [31:0] mem_rd_data,
    // write port
    input wire logic mem_wr_req,
    input wire logic [23:0] mem_wr_addr,
    input wire logic [31:0] mem_wr_data,
    output logic mem_wr_ack
);
    logic [31:0] mem [0:255];
    logic [1:0] rcnt, wcnt;
    initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
    // data toggles outside the answer cycle so stale reads show
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rd_valid <= 1'b0;
            mem_wr_ack <= 1'b0;
            mem_rd_data <= 32'h0;
            rcnt <= 2'h0;
            wcnt <= 2'h0;
        end else begin
            mem_rd_valid <= 1'b0;
            mem_wr_ack <= 1'b0;
            mem_rd_data <= ~mem_rd_data;
            if (mem_rd_req && !mem_rd_valid) begin
                rcnt <= (rcnt == lat) ? 2'h0 : rcnt + 2'h1;
                if (rcnt == lat) begin
                    mem_rd_valid <= 1'b1;
                    mem_rd_data <= mem[mem_rd_addr[7:0]];
                end
            end
            if (mem_wr_req && !mem_wr_ack) begin
                wcnt <= (wcnt == lat) ? 2'h0 : wcnt + 2'h1;
                if (wcnt == lat) begin
                    mem_wr_ack <= 1'b1;
                    mem[mem_wr_addr[7:0]] <= mem_wr_data;
                end
            end
        end
    end
endmodule // ctl_mem_model
`default_nettype wire

// File: ctl_trace_top_tb.sv
// self-checking testbench for the trace and counter block
`timescale 1ns/1ns
`default_nettype none
module ctl_trace_top_tb;
    logic core_clk, rst_n, reg_wr, reg_rd, cell_tick, prev_maint_slot, busy;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_rd_data, mem_wr_data;
    logic [2:0] egress_trace_source, ingress_trace_source;
    logic [3:0] egress_trace_cell_type, ingress_trace_cell_type;
    logic [4:0] egress_trace_reason, ingress_trace_reason;
    logic [15:0] egress_conn_id, ingress_conn_id;
    logic egress_trace_removed, egress_trace_primary_copy, egress_trace_secondary_copy, egress_oam, egress_clp;
    logic ingress_trace_removed, ingress_trace_primary_copy, ingress_trace_secondary_copy, trace_nonconforming;
    logic egress_sent, ingress_oam, ingress_clp, ingress_arrived, ingress_id_valid;
    logic mem_rd_req, mem_rd_valid, mem_wr_req, mem_wr_ack;
    logic [23:0] mem_rd_addr, mem_wr_addr;
    logic [1:0] lat;
    logic [31:0] exp_mem [0:255];
    int num_errors, cmp_count;
    int recs = 4;
    // small table keeps the wrap within a short run
    ctl_trace_top #(.MIN_RECS(4)) u_ctl_trace_top (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cell_tick, .prev_maint_slot, .egress_trace_source, .egress_trace_removed,
        .egress_trace_cell_type, .egress_trace_primary_copy, .egress_trace_secondary_copy, .egress_trace_reason,
        .egress_conn_id, .egress_oam, .egress_clp, .egress_sent, .ingress_trace_source, .ingress_trace_removed,
        .ingress_trace_cell_type, .ingress_trace_primary_copy, .ingress_trace_secondary_copy, .trace_nonconforming,
        .ingress_trace_reason, .ingress_conn_id, .ingress_oam, .ingress_clp, .ingress_arrived, .ingress_id_valid,
        .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .mem_wr_req, .mem_wr_addr, .mem_wr_data,
        .mem_wr_ack, .busy);
    ctl_mem_model u_mem (.core_clk, .rst_n, .lat, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
        .mem_wr_req, .mem_wr_addr, .mem_wr_data, .mem_wr_ack);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic run_cell(input int i);
        logic [7:0] p;
        logic [31:0] v;
        int k, idx;
        @(posedge core_clk);
        lat <= (i > 5) ? 2'h3 : 2'h0;
        {egress_trace_source, egress_trace_removed, egress_trace_cell_type} <= {i[2:0], i[0], i[3:0] + 4'h3};
        {egress_trace_primary_copy, egress_trace_secondary_copy, prev_maint_slot} <= {i[1], i[2], i[0] ^ i[1]};
        egress_trace_reason <= 5'(i * 3);
        egress_conn_id <= 16'h1000 + 16'(i);
        {ingress_trace_source, ingress_trace_removed, ingress_trace_cell_type} <= {~i[2:0], i[1], 4'hc - i[3:0]};
        {ingress_trace_primary_copy, ingress_trace_secondary_copy, trace_nonconforming} <= {i[0], i[1], i[2] ^ i[0]};
        ingress_trace_reason <= 5'(31 - i);
        ingress_conn_id <= 16'h2000 + 16'(i);
        {egress_oam, egress_clp, egress_sent} <= {i[1], i[0], i % 4 != 3};
        {ingress_oam, ingress_clp, ingress_arrived, ingress_id_valid} <= {i[2], i[1], i != 5, i % 3 != 2};
        cell_tick <= 1'b1;
        @(posedge core_clk);
        cell_tick <= 1'b0;
        p = 8'(2 * (i % recs));
        exp_mem[p] = {egress_trace_source, egress_trace_removed, egress_trace_cell_type, egress_trace_primary_copy,
            egress_trace_secondary_copy, prev_maint_slot, egress_trace_reason, egress_conn_id};
        exp_mem[p + 1] = {ingress_trace_source, ingress_trace_removed, ingress_trace_cell_type,
            ingress_trace_primary_copy, ingress_trace_secondary_copy, trace_nonconforming, ingress_trace_reason,
            ingress_conn_id};
        idx = ingress_id_valid ? 2 * ingress_oam + ingress_clp : 4;
        if (ingress_arrived) exp_mem[8'h40 + idx] += 32'h1;
        idx = 2 * egress_oam + egress_clp;
        if (egress_sent) exp_mem[8'h50 + idx] += 32'h1;
        repeat (4) @(posedge core_clk);
        for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge core_clk);
        check({31'h0, busy}, 32'h0);
        check(u_mem.mem[p], exp_mem[p]);
        check(u_mem.mem[p + 1], exp_mem[p + 1]);
        for (k = 0; k < 5; k++) check(u_mem.mem[8'h40 + k], exp_mem[8'h40 + k]);
        for (k = 0; k < 4; k++) check(u_mem.mem[8'h50 + k], exp_mem[8'h50 + k]);
        rd(4'h1, v);
        check(v, 32'(2 * ((i + 1) % recs)));
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #(100 * 20000);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] v;
        rst_n = 1'b0;
        {reg_wr, reg_rd, cell_tick, prev_maint_slot, reg_addr, reg_wdata, lat} = '0;
        {egress_trace_source, egress_trace_removed, egress_trace_cell_type, egress_trace_reason} = '0;
        {egress_trace_primary_copy, egress_trace_secondary_copy, egress_conn_id, egress_oam, egress_clp} = '0;
        {ingress_trace_source, ingress_trace_removed, ingress_trace_cell_type, ingress_trace_reason} = '0;
        {ingress_trace_primary_copy, ingress_trace_secondary_copy, trace_nonconforming, ingress_conn_id} = '0;
        {egress_sent, ingress_oam, ingress_clp, ingress_arrived, ingress_id_valid} = '0;
        for (int i = 0; i < 256; i++) exp_mem[i] = 32'h0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(4'(i), v);
            check(v, 32'h0);
        end
        wr(4'h3, 32'h40);
        wr(4'h4, 32'h50);
        wr(4'h1, 32'h7);
        wr(4'hf, 32'h5);
        wr(4'h0, 32'h0);
        rd(4'h3, v);
        check(v, 32'h40);
        rd(4'h4, v);
        check(v, 32'h50);
        rd(4'h1, v);
        check(v, 32'h0);
        rd(4'hf, v);
        check(v, 32'h0);
        $display("test registers done");
        // counter one sits at its top value to see the roll-over
        exp_mem[8'h41] = 32'hffffffff;
        u_mem.mem[8'h41] = 32'hffffffff;
        for (int i = 0; i < 12; i++) run_cell(i);
        $display("test cells done");
        // size one doubles the table; pointer sits at the base here
        wr(4'h0, 32'h1);
        rd(4'h0, v);
        check(v, 32'h1);
        recs = 8;
        for (int i = 16; i < 25; i++) run_cell(i);
        $display("test table size done");
        tally_and_finish();
    end
endmodule // ctl_trace_top_tb
`default_nettype wire
